// ---- logic/pulse_follower_pkg.sv ----
package pulse_follower_pkg;

  // register byte addresses on the plain register port
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RATIO_NUM = 8'h04;
  localparam logic [7:0] ADDR_RATIO_DEN = 8'h08;
  localparam logic [7:0] ADDR_FERR_LIMIT = 8'h0C;
  localparam logic [7:0] ADDR_ACCEL = 8'h10;
  localparam logic [7:0] ADDR_DECEL = 8'h14;
  localparam logic [7:0] ADDR_POS_CMD = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] ADDR_INPUT_COUNT = 8'h28;
  localparam logic [7:0] ADDR_MASTER_VEL = 8'h2C;
  localparam logic [7:0] ADDR_MOTOR_VEL = 8'h30;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 2;
  localparam int CTRL_CLUTCH_BIT = 3;
  localparam int CTRL_PROFILE_BIT = 4;

  // interrupt status / clear / enable layout
  localparam int IRQ_WIDTH = 2;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_BADQUAD_BIT = 1;

  // pulse follower operating mode codes
  localparam logic [2:0] MODE_QUAD = 3'h4;
  localparam logic [2:0] MODE_PULSE_DIR = 3'h5;
  localparam logic [2:0] MODE_EDGE_DIR = 3'h6;
  localparam logic [2:0] MODE_UP_DOWN = 3'h7;

  // one motor revolution on the 12-bit position scale
  localparam int POS_SCALE_BITS = 12;
  localparam int COUNTS_PER_REV = 1 << POS_SCALE_BITS;

  // velocity window: 2**VEL_WIN_BITS cycles, also the fraction width
  localparam int VEL_WIN_BITS = 8;

  // reset values
  localparam logic [2:0] RST_MODE = MODE_QUAD;
  localparam logic signed [15:0] RST_RATIO_NUM = 16'sh0001;
  localparam logic [14:0] RST_RATIO_DEN = 15'h0001;
  localparam logic [14:0] RST_FERR_LIMIT = 15'h7FFF;
  localparam logic [15:0] RST_ACCEL = 16'h0010;
  localparam logic [15:0] RST_DECEL = 16'h0010;

endpackage

// ---- logic/pulse_follower_gearing.sv ----
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module pulse_follower_gearing
  import pulse_follower_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input wire logic chanA,
  input wire logic chanB,
  input wire logic signed [31:0] actualPos,
  output logic signed [31:0] posCommand,
  output logic followingFault,
  output logic irq
);

  typedef struct packed {
    logic [2:0] aPipe;
    logic [2:0] bPipe;
    logic [2:0] mode;
    logic clutch;
    logic profile;
    logic signed [15:0] ratioNum;
    logic [14:0] ratioDen;
    logic [14:0] ferrLimit;
    logic [15:0] accelRate;
    logic [15:0] decelRate;
    logic [IRQ_WIDTH-1:0] irqStatus;
    logic [IRQ_WIDTH-1:0] irqEnable;
    logic [31:0] rdData;
    logic signed [31:0] inputCount;
    logic signed [31:0] residue;
    logic signed [31:0] masterSum;
    logic signed [31:0] masterVel;
    logic signed [31:0] motorVel;
    logic [VEL_WIN_BITS-1:0] fracAcc;
    logic [VEL_WIN_BITS-1:0] winCnt;
    logic signed [31:0] posCmd;
    logic fault;
    logic irq;
  } pf_state_s;

  pf_state_s state_ff;
  pf_state_s nxt_state;

  logic aNow, aOld, bNow, bOld, aEdge, bEdge;
  logic signed [1:0] countDelta;
  logic signed [1:0] gearDelta;
  logic signed [31:0] denSigned;
  logic signed [31:0] residueSum;
  logic signed [31:0] gearStep;
  logic signed [31:0] rampTarget;
  logic signed [31:0] rampStep;
  logic signed [31:0] fracSum;
  logic signed [31:0] motorStep;
  logic signed [31:0] posNext;
  logic signed [31:0] posErr;
  logic [31:0] posErrAbs;
  logic winEnd;
  logic badQuad;
  logic [IRQ_WIDTH-1:0] irqEvents;
  logic [IRQ_WIDTH-1:0] irqClear;

  //////////////////////////////////////////////////////////////////////////////
  // channel sampling and decoding

  // pipe[0] only feeds pipe[1]; edges compare pipe[1] with pipe[2]
  always_comb begin
    aNow = state_ff.aPipe[1];
    aOld = state_ff.aPipe[2];
    bNow = state_ff.bPipe[1];
    bOld = state_ff.bPipe[2];
    aEdge = aNow ^ aOld;
    bEdge = bNow ^ bOld;
  end

  // one count at most per cycle; inputs must be slower than the clock
  always_comb begin
    countDelta = 2'sd0;
    badQuad = 1'b0;
    case (state_ff.mode)
      MODE_QUAD: begin
        if (aEdge && bEdge) begin
          badQuad = 1'b1;
        end else if (aEdge) begin
          countDelta = (aNow != bNow) ? 2'sd1 : -2'sd1;
        end else if (bEdge) begin
          countDelta = (aNow == bNow) ? 2'sd1 : -2'sd1;
        end
      end
      MODE_PULSE_DIR: begin
        if (aEdge && aNow) begin
          countDelta = bNow ? -2'sd1 : 2'sd1;
        end
      end
      MODE_EDGE_DIR: begin
        if (aEdge) begin
          countDelta = bNow ? -2'sd1 : 2'sd1;
        end
      end
      MODE_UP_DOWN: begin
        if (aEdge && !bEdge) begin
          countDelta = 2'sd1;
        end else if (bEdge && !aEdge) begin
          countDelta = -2'sd1;
        end // both edges: no change
      end
      default: begin
        countDelta = 2'sd0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // gearing: counts times numerator over denominator, remainder kept

  // a zero denominator would divide by zero, so it is read as one
  always_comb begin
    gearDelta = state_ff.clutch ? countDelta : 2'sd0;
    denSigned = (state_ff.ratioDen == 15'h0000) ? 32'sd1 :
      $signed({17'h00000, state_ff.ratioDen});
    residueSum = state_ff.residue + 32'(gearDelta) * 32'(state_ff.ratioNum);
    gearStep = residueSum / denSigned;
  end

  //////////////////////////////////////////////////////////////////////////////
  // velocity ramp and position command

  // master velocity is counts per window; ramp steps once per window
  always_comb begin
    winEnd = (state_ff.winCnt == {VEL_WIN_BITS{1'b1}});
    rampTarget = state_ff.motorVel;
    rampStep = 32'sd0;
    if (state_ff.motorVel < state_ff.masterVel) begin
      rampStep = (state_ff.motorVel >= 0) ?
        $signed({16'h0000, state_ff.accelRate}) :
        $signed({16'h0000, state_ff.decelRate});
      rampTarget = (state_ff.masterVel - state_ff.motorVel > rampStep) ?
        state_ff.motorVel + rampStep : state_ff.masterVel;
    end else if (state_ff.motorVel > state_ff.masterVel) begin
      rampStep = (state_ff.motorVel <= 0) ?
        $signed({16'h0000, state_ff.accelRate}) :
        $signed({16'h0000, state_ff.decelRate});
      rampTarget = (state_ff.motorVel - state_ff.masterVel > rampStep) ?
        state_ff.motorVel - rampStep : state_ff.masterVel;
    end
    // fractional phase turns velocity per window into whole counts
    fracSum = $signed({24'h000000, state_ff.fracAcc}) + state_ff.motorVel;
    motorStep = fracSum >>> VEL_WIN_BITS;
    // ramped lock follows velocity only; lost offset is never chased
    posNext = state_ff.profile ? state_ff.posCmd + motorStep
      : state_ff.posCmd + gearStep;
    posErr = posNext - actualPos;
    posErrAbs = posErr[31] ? 32'(-posErr) : 32'(posErr);
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt events and register access

  always_comb begin
    irqEvents = '0;
    irqEvents[IRQ_FAULT_BIT] = posErrAbs > {17'h00000, state_ff.ferrLimit};
    irqEvents[IRQ_BADQUAD_BIT] = badQuad;
    irqClear = (regWrStb && regAddr == ADDR_IRQ_CLEAR) ? regWrData[IRQ_WIDTH-1:0] : '0;
  end

  // next-state assembly; every field written on every path
  always_comb begin
    nxt_state = state_ff;
    nxt_state.aPipe = {state_ff.aPipe[1:0], chanA};
    nxt_state.bPipe = {state_ff.bPipe[1:0], chanB};
    nxt_state.inputCount = state_ff.inputCount + 32'(countDelta);
    nxt_state.residue = residueSum - gearStep * denSigned;
    nxt_state.winCnt = state_ff.winCnt + 1'b1;
    nxt_state.masterSum = winEnd ? 32'sd0 : state_ff.masterSum + gearStep;
    if (winEnd) begin
      nxt_state.masterVel = state_ff.masterSum + gearStep;
    end
    // profile 0 keeps motor velocity on the master so a switch is smooth
    if (!state_ff.profile) begin
      nxt_state.motorVel = state_ff.masterVel;
      nxt_state.fracAcc = '0;
    end else begin
      if (winEnd) begin
        nxt_state.motorVel = rampTarget;
      end
      nxt_state.fracAcc = fracSum[VEL_WIN_BITS-1:0];
    end
    nxt_state.posCmd = posNext;
    nxt_state.fault = irqEvents[IRQ_FAULT_BIT];
    // hardware set wins over a clear in the same cycle
    nxt_state.irqStatus = (state_ff.irqStatus & ~irqClear) | irqEvents;
    nxt_state.irq = |(nxt_state.irqStatus & state_ff.irqEnable);
    if (regWrStb) begin
      case (regAddr)
        ADDR_CTRL: begin
          nxt_state.mode = regWrData[CTRL_MODE_MSB:CTRL_MODE_LSB];
          nxt_state.clutch = regWrData[CTRL_CLUTCH_BIT];
          nxt_state.profile = regWrData[CTRL_PROFILE_BIT];
        end
        ADDR_RATIO_NUM: begin
          nxt_state.ratioNum = regWrData[15:0];
        end
        ADDR_RATIO_DEN: begin
          nxt_state.ratioDen = regWrData[14:0];
        end
        ADDR_FERR_LIMIT: begin
          nxt_state.ferrLimit = regWrData[14:0];
        end
        ADDR_ACCEL: begin
          nxt_state.accelRate = regWrData[15:0];
        end
        ADDR_DECEL: begin
          nxt_state.decelRate = regWrData[15:0];
        end
        ADDR_IRQ_ENABLE: begin
          nxt_state.irqEnable = regWrData[IRQ_WIDTH-1:0];
          nxt_state.irq = |(nxt_state.irqStatus & regWrData[IRQ_WIDTH-1:0]);
        end
        default: begin
          nxt_state.irqEnable = state_ff.irqEnable; // unmapped writes ignored
        end
      endcase
    end
    // read data stand only in the cycle after the strobe
    nxt_state.rdData = '0;
    if (regRdStb) begin
      case (regAddr)
        ADDR_CTRL: begin
          nxt_state.rdData[CTRL_MODE_MSB:CTRL_MODE_LSB] = state_ff.mode;
          nxt_state.rdData[CTRL_CLUTCH_BIT] = state_ff.clutch;
          nxt_state.rdData[CTRL_PROFILE_BIT] = state_ff.profile;
        end
        ADDR_RATIO_NUM: nxt_state.rdData = 32'(state_ff.ratioNum);
        ADDR_RATIO_DEN: nxt_state.rdData = {17'h00000, state_ff.ratioDen};
        ADDR_FERR_LIMIT: nxt_state.rdData = {17'h00000, state_ff.ferrLimit};
        ADDR_ACCEL: nxt_state.rdData = {16'h0000, state_ff.accelRate};
        ADDR_DECEL: nxt_state.rdData = {16'h0000, state_ff.decelRate};
        ADDR_POS_CMD: nxt_state.rdData = state_ff.posCmd;
        ADDR_IRQ_STATUS: nxt_state.rdData = 32'(state_ff.irqStatus);
        ADDR_IRQ_ENABLE: nxt_state.rdData = 32'(state_ff.irqEnable);
        ADDR_INPUT_COUNT: nxt_state.rdData = state_ff.inputCount;
        ADDR_MASTER_VEL: nxt_state.rdData = state_ff.masterVel;
        ADDR_MOTOR_VEL: nxt_state.rdData = state_ff.motorVel;
        default: nxt_state.rdData = '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.mode <= RST_MODE;
      state_ff.ratioNum <= RST_RATIO_NUM;
      state_ff.ratioDen <= RST_RATIO_DEN;
      state_ff.ferrLimit <= RST_FERR_LIMIT;
      state_ff.accelRate <= RST_ACCEL;
      state_ff.decelRate <= RST_DECEL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from flops
  assign regRdData = state_ff.rdData;
  assign posCommand = state_ff.posCmd;
  assign followingFault = state_ff.fault;
  assign irq = state_ff.irq;

endmodule // pulse_follower_gearing

// ---- tb/pulse_follower_gearing_monitor.sv ----
`timescale 1ns/10ps
module pulse_follower_gearing_monitor
  import pulse_follower_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic chanA,
  input wire logic chanB,
  input wire logic signed [31:0] actualPos,
  input wire logic signed [31:0] posCommand,
  input wire logic followingFault,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [4:0] ctlFf;
  logic [15:0] numFf;
  logic [14:0] denFf;
  logic [14:0] limFf;
  logic [1:0] enFf;
  logic [3:0] quietCnt;
  wire pulseMode = quietCnt == 4'hF && ctlFf == {2'b01, MODE_PULSE_DIR} && numFf == 16'h0001
    && denFf == 15'h0001;
  // distance widened by one bit so no difference can wrap
  function automatic logic [32:0] mag(input logic signed [31:0] a, input logic signed [31:0] b);
    logic signed [32:0] d;
    d = 33'(a) - 33'(b);
    return d < 0 ? 33'(-d) : 33'(d);
  endfunction
  ////////////////////////////////////////////////////////////
  // shadow of the settings; quietCnt lets pipelined counts drain after a write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctlFf <= {2'b00, RST_MODE};
      numFf <= RST_RATIO_NUM;
      denFf <= RST_RATIO_DEN;
      limFf <= RST_FERR_LIMIT;
      enFf <= 2'h0;
      quietCnt <= 4'h0;
    end else begin
      if (regWrStb && regAddr == ADDR_CTRL) ctlFf <= regWrData[4:0];
      if (regWrStb && regAddr == ADDR_RATIO_NUM) numFf <= regWrData[15:0];
      if (regWrStb && regAddr == ADDR_RATIO_DEN) denFf <= regWrData[14:0];
      if (regWrStb && regAddr == ADDR_FERR_LIMIT) limFf <= regWrData[14:0];
      if (regWrStb && regAddr == ADDR_IRQ_ENABLE) enFf <= regWrData[1:0];
      if (regWrStb) quietCnt <= 4'h0;
      else if (quietCnt != 4'hF) quietCnt <= quietCnt + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  a_read_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
    else $error("read data not zero outside a read");
  a_unmapped_read_zero: assert property (regRdStb && regAddr == 8'h3C |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  a_fault_limit: assert property (
    followingFault == (mag(posCommand, $past(actualPos)) > {18'h0, $past(limFf)}))
    else $error("fault flag disagrees with limit");
  a_fault_irq: assert property (followingFault && enFf[0] |-> ##[0:2] irq)
    else $error("enabled fault gave no interrupt");
  a_masked_quiet: assert property (enFf == 2'h0 && $past(enFf) == 2'h0 |-> !irq)
    else $error("interrupt while all masked");
  a_pins_still_hold: assert property (
    ($stable(chanA) && $stable(chanB))[*8] ##0 quietCnt == 4'hF && !ctlFf[4]
    |=> $stable(posCommand)) else $error("command moved with quiet pins");
  a_clutch_off_hold: assert property (quietCnt == 4'hF && ctlFf[4:3] == 2'b00
    |=> $stable(posCommand)) else $error("command moved with clutch open");
  a_pulse_up_step: assert property (pulseMode && $rose(chanA) && !chanB
    |-> ##[2:6] posCommand == $past(posCommand) + 1) else $error("no single up step");
  a_pulse_down_step: assert property (pulseMode && $rose(chanA) && chanB
    |-> ##[2:6] posCommand == $past(posCommand) - 1) else $error("no single down step");
endmodule // pulse_follower_gearing_monitor

bind pulse_follower_gearing pulse_follower_gearing_monitor pulse_follower_gearing_monitor_inst (
  .sys_clk, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .chanA, .chanB,
  .actualPos, .posCommand, .followingFault, .irq);

// ---- tb/pulse_source_model.sv ----
`timescale 1ns/10ps
module pulse_source_model (
  input wire logic sys_clk,
  output logic chanA,
  output logic chanB
);
  int gap = 1;
  logic [1:0] ph = 2'h0;
  initial begin
    chanA = 1'b0;
    chanB = 1'b0;
  end
  // lines move just after an edge; gap 1 is the closest spacing allowed
  task automatic put(input logic a, input logic b);
    @(posedge sys_clk);
    chanA <= a;
    chanB <= b;
    repeat (gap) @(posedge sys_clk);
  endtask
  // gray order 00,10,11,01 going forward
  task automatic quad(input int n, input logic fwd);
    repeat (n) begin
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      put(ph[0] ^ ph[1], ph[1]);
    end
  endtask
  // direction settles before the first pulse edge
  task automatic pulse(input int n, input logic b);
    put(1'b0, b);
    repeat (n) begin
      put(1'b1, b);
      put(1'b0, b);
    end
  endtask
endmodule // pulse_source_model

// ---- tb/pulse_follower_gearing_tb.sv ----
`timescale 1ns/10ps
module pulse_follower_gearing_tb
  import pulse_follower_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [31:0] regRdData;
  logic chanA;
  logic chanB;
  logic signed [31:0] actualPos = 32'sh0;
  logic signed [31:0] posCommand;
  logic followingFault;
  logic irq;
  logic [31:0] rdVal;
  logic [31:0] baseCnt = 32'h0;
  logic [31:0] basePos = 32'h0;
  int nFail = 0;
  int nChecks = 0;
  int cycles = 0;
  always #25 sys_clk = ~sys_clk;
  pulse_follower_gearing pulse_follower_gearing_inst (.sys_clk, .rst, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData, .chanA, .chanB, .actualPos, .posCommand,
    .followingFault, .irq);
  pulse_source_model pulse_source_model_inst (.sys_clk, .chanA, .chanB);
  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // the full pulse train needs about 18000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      nFail++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 rdVal = regRdData;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdVal, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // counts pass a synchroniser, so let the pipeline drain before reading
  task automatic delta(input logic [31:0] dc, input logic [31:0] dp);
    repeat (8) @(posedge sys_clk);
    baseCnt = baseCnt + dc;
    basePos = basePos + dp;
    rdchk(ADDR_INPUT_COUNT, baseCnt);
    rdchk(ADDR_POS_CMD, basePos);
    chk(posCommand, basePos);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(ADDR_CTRL, 32'h4);
    rdchk(ADDR_RATIO_DEN, 32'h1);
    rdchk(ADDR_FERR_LIMIT, 32'h7FFF);
    rdchk(8'h3C, 32'h0);
    wr(ADDR_CTRL, 32'h0C);
    pulse_source_model_inst.quad(8, 1'b1);
    delta(32'h8, 32'h8);
    pulse_source_model_inst.quad(3, 1'b0);
    delta(32'hFFFFFFFD, 32'hFFFFFFFD);
    pulse_source_model_inst.put(1'b0, 1'b1);
    delta(32'h0, 32'h0);
    rdchk(ADDR_IRQ_STATUS, 32'h2);
    wr(ADDR_IRQ_CLEAR, 32'h2);
    rdchk(ADDR_IRQ_STATUS, 32'h0);
    wr(ADDR_CTRL, 32'h0D);
    pulse_source_model_inst.pulse(4096, 1'b0);
    delta(32'h1000, 32'h1000);
    pulse_source_model_inst.pulse(2, 1'b1);
    delta(32'hFFFFFFFE, 32'hFFFFFFFE);
    wr(ADDR_CTRL, 32'h0E);
    pulse_source_model_inst.pulse(3, 1'b0);
    delta(32'h6, 32'h6);
    pulse_source_model_inst.pulse(1, 1'b1);
    delta(32'hFFFFFFFE, 32'hFFFFFFFE);
    wr(ADDR_CTRL, 32'h0F);
    pulse_source_model_inst.put(1'b1, 1'b1);
    pulse_source_model_inst.put(1'b0, 1'b1);
    delta(32'h2, 32'h2);
    pulse_source_model_inst.put(1'b0, 1'b0);
    pulse_source_model_inst.put(1'b0, 1'b1);
    pulse_source_model_inst.put(1'b0, 1'b0);
    delta(32'hFFFFFFFD, 32'hFFFFFFFD);
    pulse_source_model_inst.put(1'b1, 1'b1);
    delta(32'h0, 32'h0);
    wr(ADDR_CTRL, 32'h08);
    pulse_source_model_inst.pulse(2, 1'b0);
    delta(32'h0, 32'h0);
    wr(ADDR_CTRL, 32'h0D);
    wr(ADDR_RATIO_NUM, 32'hFFFFFFFE);
    rdchk(ADDR_RATIO_NUM, 32'hFFFFFFFE);
    pulse_source_model_inst.gap = 4;
    pulse_source_model_inst.pulse(3, 1'b0);
    delta(32'h3, 32'hFFFFFFFA);
    wr(ADDR_RATIO_NUM, 32'h3);
    wr(ADDR_RATIO_DEN, 32'h2);
    pulse_source_model_inst.pulse(2, 1'b0);
    delta(32'h2, 32'h3);
    wr(ADDR_RATIO_NUM, 32'h1);
    wr(ADDR_RATIO_DEN, 32'h1);
    wr(ADDR_CTRL, 32'h05);
    pulse_source_model_inst.pulse(2, 1'b0);
    delta(32'h2, 32'h0);
    wr(ADDR_CTRL, 32'h0D);
    pulse_source_model_inst.pulse(1, 1'b0);
    delta(32'h1, 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    actualPos <= basePos - 1;
    wr(ADDR_FERR_LIMIT, 32'h1);
    settle();
    chk({31'h0, followingFault}, 32'h0);
    actualPos <= basePos - 2;
    settle();
    chk({31'h0, followingFault}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    actualPos <= basePos;
    settle();
    chk({31'h0, followingFault}, 32'h0);
    rdchk(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
    // slow ramp and two idle windows so both velocities start from zero
    wr(ADDR_ACCEL, 32'h1);
    rdchk(ADDR_ACCEL, 32'h1);
    rdchk(ADDR_DECEL, 32'h10);
    repeat (600) @(posedge sys_clk);
    wr(ADDR_CTRL, 32'h1D);
    pulse_source_model_inst.pulse(8, 1'b0);
    rd(ADDR_POS_CMD);
    chk({31'h0, $signed(rdVal - basePos) < 8}, 32'h1);
    // about 25 counts per window; motor may only climb one per window
    pulse_source_model_inst.pulse(52, 1'b0);
    rd(ADDR_MASTER_VEL);
    chk({31'h0, rdVal >= 32'h10 && rdVal <= 32'h20}, 32'h1);
    rd(ADDR_MOTOR_VEL);
    chk({31'h0, rdVal >= 32'h1 && rdVal <= 32'h3}, 32'h1);
    conclude();
  end
endmodule // pulse_follower_gearing_tb
